// ==== fct_regs.svh ====
// register offsets, field positions, reset values and timing figures of the fixed-cycle timer
`ifndef FCT_REGS_SVH
`define FCT_REGS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define FCT_OFS_CTRL2      8'h01
`define FCT_OFS_TCTRL      8'h0e
`define FCT_OFS_PRESET     8'h0f

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define FCT_BIT_TIE        0
`define FCT_BIT_TF         2
`define FCT_BIT_MODE       4
`define FCT_BIT_TE         7
`define FCT_TD_HI          1
`define FCT_TD_LO          0

// ---------------------------------------------------------------
// source select codes and count values
// ---------------------------------------------------------------
`define FCT_TD_4096        2'h0
`define FCT_TD_64          2'h1
`define FCT_TD_SEC         2'h2
`define FCT_TD_MIN         2'h3
`define FCT_CNT_ONE        8'h01
`define FCT_CNT_ZERO       8'h00
`define FCT_RST_BYTE       8'h00

// ---------------------------------------------------------------
// auto-return times in ns, and the clock period
// ---------------------------------------------------------------
`define FCT_CLK_PERIOD_NS  10
`define FCT_RTN_122US_NS   122000
`define FCT_RTN_244US_NS   244000
`define FCT_RTN_7813US_NS  7813000
`define FCT_RTN_15625US_NS 15625000
`define FCT_RTN_W          21

`endif

// ==== fct_pkg.sv ====
// types shared by the fixed-cycle timer
`include "fct_regs.svh"
package fct_pkg;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef logic [`FCT_RTN_W-1:0] fct_rtn_t;

  // register access from the serial interface logic
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fct_req_s;

  // timebase strobes, one cycle each
  typedef struct packed {
    logic t4096;
    logic t64;
    logic sec;
    logic min;
  } fct_tick_s;

  // whole state of the timer
  typedef struct packed {
    logic       mode;
    logic       tf;
    logic       timer_irq_enable;
    logic       te;
    logic [1:0] td;
    logic [7:0] preset;
    logic [7:0] count;
    logic       valid;
    fct_rtn_t   rtn;
    logic       irq_oe;
    logic [7:0] rdata;
  } fct_state_s;

endpackage

// ==== fct_timer.sv ====
// fixed-cycle countdown timer with open-drain interrupt output
`include "fct_regs.svh"

module fct_timer #(
  parameter int RTN_122US_CYC   = `FCT_RTN_122US_NS / `FCT_CLK_PERIOD_NS,
  parameter int RTN_244US_CYC   = `FCT_RTN_244US_NS / `FCT_CLK_PERIOD_NS,
  parameter int RTN_7813US_CYC  = `FCT_RTN_7813US_NS / `FCT_CLK_PERIOD_NS,
  parameter int RTN_15625US_CYC = `FCT_RTN_15625US_NS / `FCT_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // register port from the serial interface
  input  wire fct_pkg::fct_req_s req,
  output logic [7:0]             reg_rdata,
  // timebase strobes
  input  wire fct_pkg::fct_tick_s tick,
  // open-drain interrupt pin
  input  wire logic              irq_pin_in,
  output logic                   irq_pin_out,
  output logic                   irq_pin_oe
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fct_pkg::fct_state_s s_q;
  fct_pkg::fct_state_s s_d;
  logic                ev;
  logic                src_tick;
  logic                wr_ctrl2;
  logic                wr_tctrl;
  logic                wr_preset;
  logic                pin_q;

  // pick the tick of the selected source
  function automatic logic sel_tick(input logic [1:0] td,
                                    input fct_pkg::fct_tick_s t);
    logic r;
    r = 1'b0;
    case (td)
      `FCT_TD_4096: r = t.t4096;
      `FCT_TD_64:   r = t.t64;
      `FCT_TD_SEC:  r = t.sec;
      `FCT_TD_MIN:  r = t.min;
      default:      r = 1'b0;
    endcase
    return r;
  endfunction

  // auto-return length, depends on source and on a preset of one
  function automatic fct_pkg::fct_rtn_t rtn_len(input logic [1:0] td,
                                                input logic [7:0] pre);
    fct_pkg::fct_rtn_t r;
    logic              one;
    one = (pre == `FCT_CNT_ONE);
    case (td)
      `FCT_TD_4096: r = one ? fct_pkg::fct_rtn_t'(RTN_122US_CYC)
                            : fct_pkg::fct_rtn_t'(RTN_244US_CYC);
      `FCT_TD_64:   r = one ? fct_pkg::fct_rtn_t'(RTN_7813US_CYC)
                            : fct_pkg::fct_rtn_t'(RTN_15625US_CYC);
      default:      r = fct_pkg::fct_rtn_t'(RTN_15625US_CYC);
    endcase
    return r;
  endfunction

  // register address decode
  function automatic logic hit(input fct_pkg::fct_req_s r, input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------

  // decode of the three writable registers
  assign wr_ctrl2  = hit(req, `FCT_OFS_CTRL2);
  assign wr_tctrl  = hit(req, `FCT_OFS_TCTRL);
  assign wr_preset = hit(req, `FCT_OFS_PRESET);
  assign src_tick  = sel_tick(s_q.td, tick);

  // countdown first, register writes after, flag set last so it wins
  always_comb begin
    s_d = s_q;
    ev  = 1'b0;

    // countdown runs only on a valid preset with the enable set
    if (s_q.te && s_q.valid && src_tick) begin
      if (s_q.count == `FCT_CNT_ONE) begin
        ev        = 1'b1;
        s_d.count = s_q.preset;
      end else begin
        s_d.count = s_q.count - `FCT_CNT_ONE;
      end
    end

    // auto-return counter winds down on its own
    if (s_q.rtn != '0) begin
      s_d.rtn = s_q.rtn - fct_pkg::fct_rtn_t'(1);
    end
    // a new event in repeated mode restarts the low pulse
    if (ev && s_q.mode && s_q.timer_irq_enable) begin
      s_d.rtn = rtn_len(s_q.td, s_q.preset);
    end

    // timer control: enable and source select
    if (wr_tctrl) begin
      s_d.te = req.wdata[`FCT_BIT_TE];
      s_d.td = {req.wdata[`FCT_TD_HI], req.wdata[`FCT_TD_LO]};
      // stopping discards both count and preset; restart needs a rewrite
      if (s_q.te && !req.wdata[`FCT_BIT_TE]) begin
        s_d.valid  = 1'b0;
        s_d.count  = `FCT_CNT_ZERO;
        s_d.preset = `FCT_CNT_ZERO;
      end
    end

    // preset is taken only while stopped; a zero preset never arms
    if (wr_preset && !s_q.te) begin
      s_d.preset = req.wdata;
      s_d.count  = req.wdata;
      s_d.valid  = (req.wdata != `FCT_CNT_ZERO);
    end

    // control 2: mode, interrupt enable, flag clear by writing zero
    if (wr_ctrl2) begin
      s_d.mode = req.wdata[`FCT_BIT_MODE];
      s_d.timer_irq_enable  = req.wdata[`FCT_BIT_TIE];
      if (!req.wdata[`FCT_BIT_TF]) begin
        s_d.tf = 1'b0;
      end                                  // writing one leaves it
    end

    // event sets the sticky flag, winning over a clear in the same cycle
    if (ev) begin
      s_d.tf = 1'b1;
    end

    // disabled interrupt enable cuts any pulse short
    if (!s_d.timer_irq_enable) begin
      s_d.rtn = '0;
    end

    // pin enable: held by the flag in level mode, pulse in repeated mode
    if (s_d.mode) begin
      s_d.irq_oe = s_d.timer_irq_enable && (s_d.rtn != '0);
    end else begin
      s_d.irq_oe = s_d.timer_irq_enable && s_d.tf;
    end

    // read data, registered; the count is live and not latched
    if (req.rd) begin
      case (req.addr)
        `FCT_OFS_CTRL2: begin
          s_d.rdata = `FCT_RST_BYTE;
          s_d.rdata[`FCT_BIT_MODE] = s_q.mode;
          s_d.rdata[`FCT_BIT_TF]   = s_q.tf;
          s_d.rdata[`FCT_BIT_TIE]  = s_q.timer_irq_enable;
        end
        `FCT_OFS_TCTRL: begin
          s_d.rdata = `FCT_RST_BYTE;
          s_d.rdata[`FCT_BIT_TE] = s_q.te;
          s_d.rdata[`FCT_TD_HI]  = s_q.td[1];
          s_d.rdata[`FCT_TD_LO]  = s_q.td[0];
        end
        `FCT_OFS_PRESET: s_d.rdata = s_q.count;
        default:         s_d.rdata = `FCT_RST_BYTE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------

  // whole state in one flop bank
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // pin level sampled but unused; the line is shared with other sources
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_q       <= 1'b0;
      irq_pin_out <= 1'b0;
    end else begin
      pin_q       <= irq_pin_in;
      irq_pin_out <= 1'b0; // open drain only ever pulls low
    end
  end

  // outputs come straight from the state flops
  assign reg_rdata  = s_q.rdata;
  assign irq_pin_oe = s_q.irq_oe;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------

  flag_set_a: assert property (
    @(posedge clk) disable iff (!rstn) ev |=> s_q.tf)
    else $error("flag not set after event");

  flag_hold_a: assert property (
    @(posedge clk) disable iff (!rstn)
    s_q.tf && !(wr_ctrl2 && !req.wdata[`FCT_BIT_TF]) |=> s_q.tf)
    else $error("flag dropped without clear");

  flag_clear_a: assert property (
    @(posedge clk) disable iff (!rstn)
    wr_ctrl2 && !req.wdata[`FCT_BIT_TF] && !ev |=> !s_q.tf)
    else $error("flag not cleared by zero write");

  flag_one_a: assert property (
    @(posedge clk) disable iff (!rstn)
    wr_ctrl2 && req.wdata[`FCT_BIT_TF] && !s_q.tf && !ev |=> !s_q.tf)
    else $error("writing one changed flag");

  count_dec_a: assert property (
    @(posedge clk) disable iff (!rstn)
    s_q.te && s_q.valid && src_tick && s_q.count != `FCT_CNT_ONE
      && !wr_tctrl |=> s_q.count == $past(s_q.count) - `FCT_CNT_ONE)
    else $error("count did not step down by one");

  count_reload_a: assert property (
    @(posedge clk) disable iff (!rstn)
    ev && !wr_tctrl |=> s_q.count == s_q.preset && s_q.valid)
    else $error("count did not reload preset");

  stop_invalid_a: assert property (
    @(posedge clk) disable iff (!rstn)
    $fell(s_q.te) |-> !s_q.valid && s_q.count == `FCT_CNT_ZERO)
    else $error("count valid after stop");

  enable_rb_a: assert property (
    @(posedge clk) disable iff (!rstn)
    wr_tctrl |=> s_q.te == $past(req.wdata[`FCT_BIT_TE]))
    else $error("enable does not hold written value");

  level_pin_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !s_q.mode |-> irq_pin_oe == (s_q.timer_irq_enable && s_q.tf))
    else $error("level output does not follow flag");

  tie_off_a: assert property (
    @(posedge clk) disable iff (!rstn) !s_q.timer_irq_enable |-> !irq_pin_oe)
    else $error("output driven with enable off");

  pulse_start_a: assert property (
    @(posedge clk) disable iff (!rstn)
    ev && s_q.mode && s_q.timer_irq_enable && !wr_ctrl2 ##1 !wr_ctrl2 |-> irq_pin_oe)
    else $error("repeated pulse missing");

  read_live_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && req.addr == `FCT_OFS_PRESET |=> reg_rdata == $past(s_q.count))
    else $error("counter read not live");

  no_drive_high_a: assert property (
    @(posedge clk) disable iff (!rstn) !irq_pin_out)
    else $error("pin driven high");

endmodule

// ==== fct_host_model.sv ====
// host-side model: register access tasks and the pulled-up interrupt line
`include "fct_regs.svh"
module fct_host_model (
  // clock
  input  wire logic         clk,
  // register port toward the timer
  output fct_pkg::fct_req_s req,
  input  wire logic [7:0]   reg_rdata,
  // interrupt pin as seen by the host
  input  wire logic         irq_pin_out,
  input  wire logic         irq_pin_oe,
  output logic              irq_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // pull-up holds the line high whenever the timer lets go
  assign irq_line = irq_pin_oe ? irq_pin_out : 1'b1;
  initial req = '0;

  // one request per call; the idle bus shows a changing pattern
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00);
    #1 d = reg_rdata;
  endtask

  // stop, load a nonzero preset, and only then enable
  task automatic start(input logic [7:0] p, input logic [1:0] td);
    xfer(1'b1, `FCT_OFS_TCTRL, 8'h00);
    xfer(1'b1, `FCT_OFS_PRESET, (p == 8'h00) ? 8'h01 : p);
    xfer(1'b1, `FCT_OFS_TCTRL, {6'h20, td});
  endtask

  // the count is not latched, so read pairs until two reads agree, at most four pairs
  task automatic rd_count(output logic [7:0] d);
    logic [7:0] a;
    a = 8'h00;
    d = 8'hff;
    for (int k = 0; k < 4 && a !== d; k++) begin
      rd(`FCT_OFS_PRESET, a);
      rd(`FCT_OFS_PRESET, d);
    end
  endtask
endmodule

// ==== fixed_cycle_timer_interrupt_tb_top.sv ====
// self-checking bench comparing the timer with a cycle model
`include "fct_regs.svh"
module fixed_cycle_timer_interrupt_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N1 = 4, N2 = 8, N3 = 16, N4 = 32;
  logic               clk, rstn, irq_line, irq_pin_out, irq_pin_oe;
  logic [7:0]         reg_rdata, d, m_cnt, m_pre, m_rd;
  fct_pkg::fct_req_s  req;
  fct_pkg::fct_tick_s tick;
  logic               m_te, m_ok, m_tf, m_tie, m_mode, m_oe, sel, ev;
  logic [1:0]         m_td;
  int                 errors, cmp_count, m_pls;

  fct_timer #(.RTN_122US_CYC(N1), .RTN_244US_CYC(N2),
    .RTN_7813US_CYC(N3), .RTN_15625US_CYC(N4)) dut_u (
    .clk(clk), .rstn(rstn), .req(req), .reg_rdata(reg_rdata), .tick(tick),
    .irq_pin_in(irq_line), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));
  fct_host_model host_u (.clk(clk), .req(req), .reg_rdata(reg_rdata),
    .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe), .irq_line(irq_line));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // sparse random strobes on all four timebase taps
  always @(posedge clk) tick <= fct_pkg::fct_tick_s'(4'($urandom_range(15) & $urandom_range(15)));

  // cycle model; the read is taken before this edge's updates
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {m_te, m_ok, m_tf, m_tie, m_mode, m_oe, m_td, m_cnt, m_pre, m_rd} = '0;
      m_pls = 0;
    end else begin
      if (req.rd) m_rd = (req.addr == `FCT_OFS_CTRL2) ? {3'h0, m_mode, 1'b0, m_tf, 1'b0, m_tie}
        : (req.addr == `FCT_OFS_TCTRL) ? {m_te, 5'h00, m_td}
        : (req.addr == `FCT_OFS_PRESET) ? m_cnt : 8'h00;
      sel = tick[3 - m_td];
      ev = m_te && m_ok && sel && m_cnt == 8'h01;
      if (m_pls > 0) m_pls--;
      // pulse restart sees mode, enable, source and preset from before this edge's writes
      if (ev && m_mode && m_tie) m_pls = m_td[1] ? N4
        : m_td[0] ? (m_pre == 8'h01 ? N3 : N4) : (m_pre == 8'h01 ? N1 : N2);
      if (m_te && m_ok && sel) m_cnt = ev ? m_pre : m_cnt - 8'h01;
      if (req.wr && req.addr == `FCT_OFS_CTRL2) begin
        m_mode = req.wdata[4];
        m_tie = req.wdata[0];
        if (!req.wdata[2]) m_tf = 1'b0;
      end
      if (req.wr && req.addr == `FCT_OFS_PRESET && !m_te) begin
        {m_pre, m_cnt} = {2{req.wdata}};
        m_ok = req.wdata != 8'h00;
      end
      if (req.wr && req.addr == `FCT_OFS_TCTRL) begin
        if (m_te && !req.wdata[7]) {m_pre, m_cnt, m_ok} = '0;
        {m_te, m_td} = {req.wdata[7], req.wdata[1:0]};
      end
      if (ev) m_tf = 1'b1;
      if (!m_tie) m_pls = 0;
      m_oe = m_tie && (m_mode ? m_pls > 0 : m_tf);
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // outputs are settled mid-cycle, so all three are compared on every falling edge
  always @(negedge clk) begin
    check("irq_pin_oe", {7'h00, irq_pin_oe}, {7'h00, m_oe});
    check("irq_pin_out", {7'h00, irq_pin_out}, 8'h00);
    check("reg_rdata", reg_rdata, m_rd);
  end

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_line !== 1'b0 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    check("irq_wait", {7'h00, n < 3000}, 8'h01);
  endtask

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog beyond sixteen capped interrupt waits, still under the cycle budget
  initial begin
    #800000;
    errors++;
    end_of_test();
  end

  // every mode and source, with flag, enable and stop handling in each
  initial begin
    rstn = 1'b0;
    errors = 0;
    cmp_count = 0;
    void'($urandom(32'hde195222));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      host_u.xfer(1'b1, `FCT_OFS_CTRL2, {3'h0, i[2], 4'h1});
      host_u.start(i[1:0] == 2'h3 ? 8'hff : 8'($urandom_range(3) + 1), i[1:0]);
      wait_irq();
      host_u.rd_count(d);
      host_u.xfer(1'b1, `FCT_OFS_CTRL2, {3'h0, i[2], 4'h4});
      host_u.xfer(1'b1, `FCT_OFS_CTRL2, {3'h0, i[2], 4'h5});
      host_u.xfer(1'b1, `FCT_OFS_CTRL2, {3'h0, i[2], 4'h1});
      wait_irq();
      host_u.xfer(1'b1, `FCT_OFS_PRESET, 8'h07);
      host_u.rd(`FCT_OFS_TCTRL, d);
      host_u.xfer(1'b1, `FCT_OFS_TCTRL, 8'h00);
      host_u.rd(`FCT_OFS_PRESET, d);
      host_u.rd(`FCT_OFS_CTRL2, d);
    end
    host_u.xfer(1'b1, 8'h05, 8'hff);
    host_u.rd(8'h05, d);
    host_u.xfer(1'b1, `FCT_OFS_PRESET, 8'h00);
    host_u.xfer(1'b1, `FCT_OFS_TCTRL, 8'h80);
    repeat (60) @(posedge clk);
    host_u.rd(`FCT_OFS_PRESET, d);
    end_of_test();
  end
endmodule
